// File: src/spi_link_pkg.sv
// Purpose: shared constants for the serial link block
// Assumes: 16-bit register port, word offsets
// Notes: register offsets chosen for this block
package spi_link_pkg;
   // register offsets
   localparam logic [3:0] OFF_LINK_CTL = 4'h0;
   localparam logic [3:0] OFF_CHAR_CTL = 4'h1;
   localparam logic [3:0] OFF_BAUD = 4'h2;
   localparam logic [3:0] OFF_TXDATA = 4'h3;
   localparam logic [3:0] OFF_RXDATA = 4'h4;
   localparam logic [3:0] OFF_STATUS = 4'h5;
   // field positions
   localparam int BIT_MASTER = 2;
   localparam int BIT_PHASE = 3;
   localparam int BIT_POLARITY = 6;
   localparam int BIT_BUSY = 0;
   localparam int BIT_DONE = 1;
   // reset values
   localparam logic [15:0] RST_LINK_CTL = 16'h0000;
   localparam logic [15:0] RST_CHAR_CTL = 16'h0000;
   localparam logic [6:0] RST_BAUD = 7'h03;
   // timing: baud divisor range, period = divisor + 1 system cycles
   localparam int BAUD_MIN = 3;
   localparam int BAUD_MAX = 127;
   // slave: external clock period at least eight system cycles
   localparam int SLAVE_MIN_PERIOD = 8;
   // word length
   localparam int WORD_BITS = 8;
endpackage

// File: src/spi_pin_sync.sv
// Purpose: three-stage synchroniser for link pins
// Assumes: inputs asynchronous to i_sys_clk
// Notes: level changes once stages two and three agree
`timescale 1ns/10ps
module spi_pin_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // pins in, clean levels out
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] stage1; // first stage, read only by stage2
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   // shift pins through three flops
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         o_level <= '0;
      end else begin
         stage1 <= i_pin;
         stage2 <= stage1;
         stage3 <= stage2;
         // filter: accept only when two later stages agree
         for (int k = 0; k < WIDTH; k++) begin
            if (stage2[k] == stage3[k]) begin
               o_level[k] <= stage3[k];
            end
         end
      end
   end
endmodule

// File: src/spi_baud_gen.sv
// Purpose: serial clock tick generator for master role
// Assumes: divisor in range 3..127, period divisor+1 cycles
// Notes: odd periods give phases one cycle apart in length
`timescale 1ns/10ps
module spi_baud_gen (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_run,
   input wire logic [6:0] i_divisor,
   // ticks: first half end, second half end
   output logic o_half,
   output logic o_full
);
   logic [6:0] count; // position within period
   wire [7:0] period = {1'b0, i_divisor} + 8'h01;
   // idle-level phase ceil(p/2), so an odd period leaves the active phase one cycle short
   wire [6:0] half_at = period[7:1] + {6'h00, period[0]} - 7'h01; // RULE7
   wire [6:0] full_at = i_divisor;
   // period counter, restarts whenever idle
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || !i_run) begin
         count <= 7'h00;
         o_half <= 1'b0;
         o_full <= 1'b0;
      end else begin
         o_half <= (count == half_at);
         o_full <= (count == full_at); // RULE5
         count <= (count == full_at) ? 7'h00 : count + 7'h01;
      end
   end
endmodule

// File: src/spi_link_core.sv
// Purpose: serial link master/slave with phase and polarity select
// Assumes: 16-bit register port, single 10 MHz system clock
// Notes: 8-bit words, msb first
//
// Contract
// RULE1 - control bit 2 set selects master
// RULE2 - control bit 3 selects clock phase
// RULE3 - char control bit 6 selects clock polarity
// RULE4 - strobe active across whole transfer
// RULE5 - master period is divisor plus one cycles
// RULE6 - external clock period at least eight cycles
// RULE7 - odd period splits phases unevenly
`timescale 1ns/10ps
module spi_link_core (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // serial clock pin, two-way
   input wire logic i_serial_clock_pin,
   output logic o_serial_clock_pin,
   output logic o_serial_clock_pin_oe,
   // master out slave in, two-way
   input wire logic i_master_out_slave_in_pin,
   output logic o_master_out_slave_in_pin,
   output logic o_master_out_slave_in_pin_oe,
   // master in slave out, two-way
   input wire logic i_master_in_slave_out_pin,
   output logic o_master_in_slave_out_pin,
   output logic o_master_in_slave_out_pin_oe,
   // transfer enable strobe, active low, two-way
   input wire logic i_transfer_enable_strobe_n,
   output logic o_transfer_enable_strobe_n,
   output logic o_transfer_enable_strobe_n_oe
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_SHIFT = 2'b10,
      ST_TRAIL = 2'b11
   } state_type;

   state_type state; // master sequencer
   logic [15:0] link_control_reg; // role and phase
   logic [15:0] char_control_reg; // polarity
   logic [6:0] baud_divider; // period minus one
   logic [7:0] tx_word; // word to send
   logic [7:0] rx_word; // last received word
   logic [7:0] shreg; // shift register
   logic [3:0] bit_cnt; // trailing edges remaining in word
   logic busy; // transfer in progress
   logic done; // sticky word complete
   logic clk_level; // internal clock, polarity applied at pin
   logic out_bit; // bit launched onto data out
   logic sample_bit; // last sampled bit, never read; shifts take din directly
   logic [2:0] s_prev; // previous synced pin levels

   // control fields
   wire is_master = link_control_reg[spi_link_pkg::BIT_MASTER]; // RULE1
   wire phase1 = link_control_reg[spi_link_pkg::BIT_PHASE]; // RULE2
   wire polarity = char_control_reg[spi_link_pkg::BIT_POLARITY]; // RULE3

   // register decode
   wire wr_link = i_wr && (i_addr == spi_link_pkg::OFF_LINK_CTL);
   wire wr_char = i_wr && (i_addr == spi_link_pkg::OFF_CHAR_CTL);
   wire wr_baud = i_wr && (i_addr == spi_link_pkg::OFF_BAUD);
   wire wr_tx = i_wr && (i_addr == spi_link_pkg::OFF_TXDATA);
   wire rd_rx = i_rd && (i_addr == spi_link_pkg::OFF_RXDATA);
   // clamp divisor so the period never drops under four cycles
   wire [6:0] baud_eff = (baud_divider < 7'(spi_link_pkg::BAUD_MIN)) ?
                         7'(spi_link_pkg::BAUD_MIN) : baud_divider; // RULE5

   // synchronised pins: clock, data in (slave), strobe
   logic [2:0] s_lvl;
   spi_pin_sync #(.WIDTH(3)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      // strobe enters inverted so the synchroniser's zero reset matches its idle level
      .i_pin({i_serial_clock_pin, i_master_out_slave_in_pin, !i_transfer_enable_strobe_n}),
      .o_level(s_lvl)
   );
   // master samples data in directly; period of 4+ cycles covers skew
   wire miso_in = i_master_in_slave_out_pin;

   // master tick generator
   logic tick_half;
   logic tick_full;
   spi_baud_gen u_baud (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_run(is_master && (state == ST_SHIFT)),
      .i_divisor(baud_eff),
      .o_half(tick_half),
      .o_full(tick_full)
   );

   // slave edges seen after sync; valid only at period >= 8 cycles
   wire s_sclk = s_lvl[2] ^ polarity; // RULE3
   wire s_rise = s_sclk && !(s_prev[2] ^ polarity); // RULE6
   wire s_fall = !s_sclk && (s_prev[2] ^ polarity); // RULE6
   wire s_sel = s_lvl[0]; // RULE4
   wire s_sel_start = s_sel && !s_prev[0];
   // phase 0: sample on leading edge, launch on trailing
   // phase 1: launch on leading edge, sample on trailing
   wire lead_edge = is_master ? tick_half : s_rise;
   wire trail_edge = is_master ? tick_full : s_fall;
   wire sample_edge = phase1 ? trail_edge : lead_edge; // RULE2
   wire launch_edge = phase1 ? lead_edge : trail_edge; // RULE2
   wire din = is_master ? miso_in : s_lvl[1];
   wire active = is_master ? (state == ST_SHIFT) : (s_sel && busy);

   // registers
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         link_control_reg <= spi_link_pkg::RST_LINK_CTL;
         char_control_reg <= spi_link_pkg::RST_CHAR_CTL;
         baud_divider <= spi_link_pkg::RST_BAUD;
         tx_word <= 8'h00;
      end else begin
         // role change ignored mid transfer
         if (wr_link && !busy) begin
            link_control_reg <= i_wdata;
         end
         if (wr_char && !busy) begin
            char_control_reg <= i_wdata;
         end
         if (wr_baud && !busy) begin
            baud_divider <= i_wdata[6:0];
         end
         if (wr_tx) begin
            tx_word <= i_wdata[7:0];
         end
      end
   end

   // read data, one cycle after strobe; unmapped reads zero
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            spi_link_pkg::OFF_LINK_CTL: o_rdata <= link_control_reg;
            spi_link_pkg::OFF_CHAR_CTL: o_rdata <= char_control_reg;
            spi_link_pkg::OFF_BAUD: o_rdata <= {9'h000, baud_divider};
            spi_link_pkg::OFF_TXDATA: o_rdata <= {8'h00, tx_word};
            spi_link_pkg::OFF_RXDATA: o_rdata <= {8'h00, rx_word};
            spi_link_pkg::OFF_STATUS: o_rdata <= {14'h0000, done, busy};
            default: o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // transfer engine, shared by both roles
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
         shreg <= 8'h00;
         rx_word <= 8'h00;
         bit_cnt <= 4'h0;
         busy <= 1'b0;
         done <= 1'b0;
         clk_level <= 1'b0;
         out_bit <= 1'b0;
         sample_bit <= 1'b0;
         s_prev <= 3'b000;
      end else begin
         s_prev <= s_lvl;
         // set wins over clear: done clear only without a new completion
         if (rd_rx) begin
            done <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               clk_level <= 1'b0;
               if (is_master && wr_tx) begin
                  // load word; phase 0 needs first bit before first edge
                  shreg <= i_wdata[7:0];
                  out_bit <= i_wdata[7];
                  bit_cnt <= 4'(spi_link_pkg::WORD_BITS);
                  busy <= 1'b1;
                  state <= ST_LEAD; // RULE4
               end else if (!is_master && s_sel_start) begin
                  shreg <= tx_word;
                  out_bit <= tx_word[7];
                  bit_cnt <= 4'(spi_link_pkg::WORD_BITS);
                  busy <= 1'b1;
               end
            end
            // strobe low at least four cycles before the first clock edge
            ST_LEAD: state <= ST_SHIFT; // RULE4
            ST_SHIFT: begin
               if (tick_half) begin
                  clk_level <= 1'b1;
               end
               if (tick_full) begin
                  clk_level <= 1'b0;
               end
               // last bit done: keep strobe for one more cycle
               if (bit_cnt == 4'h0) begin
                  state <= ST_TRAIL; // RULE4
               end
            end
            ST_TRAIL: begin
               busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
         if (active) begin
            if (sample_edge) begin
               sample_bit <= din;
               if (!phase1) begin
                  shreg <= {shreg[6:0], din};
               end
            end
            if (launch_edge) begin
               if (phase1) begin
                  // first leading edge launches msb
                  out_bit <= shreg[7];
               end else begin
                  out_bit <= shreg[7];
               end
            end
            // trailing edge ends a bit time in every mode
            if (trail_edge) begin
               bit_cnt <= bit_cnt - 4'h1;
               if (phase1) begin
                  shreg <= {shreg[6:0], din};
               end
               if (bit_cnt == 4'h1) begin
                  rx_word <= phase1 ? {shreg[6:0], din} : shreg;
                  done <= 1'b1;
                  if (!is_master) begin
                     busy <= 1'b0;
                  end
               end
            end
         end
         // slave aborts if strobe released early
         if (!is_master && busy && !s_sel) begin
            busy <= 1'b0;
         end
      end
   end

   // pin drivers, all registered
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_serial_clock_pin <= 1'b0;
         o_serial_clock_pin_oe <= 1'b0;
         o_master_out_slave_in_pin <= 1'b0;
         o_master_out_slave_in_pin_oe <= 1'b0;
         o_master_in_slave_out_pin <= 1'b0;
         o_master_in_slave_out_pin_oe <= 1'b0;
         o_transfer_enable_strobe_n <= 1'b1;
         o_transfer_enable_strobe_n_oe <= 1'b0;
      end else begin
         // master drives clock, data out, strobe; slave drives data in
         o_serial_clock_pin <= clk_level ^ polarity; // RULE3
         o_serial_clock_pin_oe <= is_master; // RULE1
         o_master_out_slave_in_pin <= out_bit;
         o_master_out_slave_in_pin_oe <= is_master;
         o_master_in_slave_out_pin <= out_bit;
         o_master_in_slave_out_pin_oe <= !is_master && s_sel;
         o_transfer_enable_strobe_n <= !(is_master && (state != ST_IDLE)); // RULE4
         o_transfer_enable_strobe_n_oe <= is_master;
      end
   end
endmodule

// File: tb/spi_link_checker.sv
// Purpose: port-level assertions for the serial link core
// Assumes: setup registers written only while the strobe is idle
// Notes: shadows of accepted setup writes stand in for the registers
`timescale 1ns/10ps
module spi_link_checker (
   // clock, reset, register writes
   input wire logic i_sys_clk, i_sys_rst, i_wr,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   // pins driven by the core
   input wire logic o_serial_clock_pin, o_serial_clock_pin_oe,
   input wire logic o_master_out_slave_in_pin, o_master_out_slave_in_pin_oe,
   input wire logic o_master_in_slave_out_pin_oe,
   input wire logic o_transfer_enable_strobe_n, o_transfer_enable_strobe_n_oe
);
   logic [2:0] age; // cycles since a setup write, stops at four
   logic [15:0] ctl, chr; // control shadows
   logic [7:0] txd, per, cnt; // byte sent, period, phase length so far
   logic sq, seen; // last clock level, leading edge seen in frame
   wire logic sck = o_serial_clock_pin;
   wire logic ste = o_transfer_enable_strobe_n;
   wire logic pol = chr[spi_link_pkg::BIT_POLARITY];
   wire logic lead = sq == pol && sck != pol; // clock leaves idle
   wire logic trail = sq != pol && sck == pol; // clock back at idle
   wire logic ready = age == 3'h4 && o_serial_clock_pin_oe;
   // busy writes are refused, so only idle writes move a shadow
   wire logic setup = i_wr && i_addr <= spi_link_pkg::OFF_BAUD && ste;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // shadows and edge counters; a divisor under three counts as three
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         age <= 3'h0;
         ctl <= 16'h0000;
         chr <= 16'h0000;
         txd <= 8'h00;
         per <= 8'h04;
         sq <= 1'b0;
         cnt <= 8'h00;
         seen <= 1'b0;
      end else begin
         age <= setup ? 3'h0 : (age == 3'h4 ? age : age + 3'h1);
         if (setup && i_addr == spi_link_pkg::OFF_LINK_CTL) ctl <= i_wdata;
         if (setup && i_addr == spi_link_pkg::OFF_CHAR_CTL) chr <= i_wdata;
         if (setup && i_addr == spi_link_pkg::OFF_BAUD) per <= i_wdata[6:0] < 7'h03 ? 8'h04 : 8'(i_wdata[6:0]) + 8'h01;
         if (i_wr && i_addr == spi_link_pkg::OFF_TXDATA && ste) txd <= i_wdata[7:0];
         sq <= sck;
         cnt <= sq != sck ? 8'h01 : cnt + 8'h01;
         seen <= ste ? 1'b0 : (lead | seen);
      end
   end
   a_role_drives: assert property (age == 3'h4 |-> o_serial_clock_pin_oe == ctl[spi_link_pkg::BIT_MASTER]
      && o_transfer_enable_strobe_n_oe == o_serial_clock_pin_oe && o_master_out_slave_in_pin_oe == o_serial_clock_pin_oe)
      else $error("pin drive does not follow role bit");
   a_slave_answer: assert property (o_master_in_slave_out_pin_oe |-> !o_serial_clock_pin_oe)
      else $error("slave data driven in master role");
   a_idle_level: assert property (ready && ste |-> sck == pol)
      else $error("clock idle level wrong");
   a_strobe_covers: assert property (ready && sck != pol |-> !ste)
      else $error("clock active outside strobe");
   a_strobe_hold: assert property (ready && $fell(ste) |-> !ste [*8])
      else $error("strobe released early");
   a_lead_length: assert property (ready && seen && trail |-> cnt == 8'(per[7:1]))
      else $error("leading phase length wrong");
   a_baud_period: assert property (ready && seen && lead |-> cnt == per - 8'(per[7:1]))
      else $error("clock period wrong");
   a_first_bit: assert property (ready && lead && !seen && !ctl[spi_link_pkg::BIT_PHASE]
      |-> o_master_out_slave_in_pin == txd[7]) else $error("first bit not set up");
   a_phase_hold: assert property (ready && !ste && (ctl[spi_link_pkg::BIT_PHASE] ? trail : lead)
      |-> $stable(o_master_out_slave_in_pin)) else $error("data moved on sampling edge");
   c_odd_period: cover property (ready && seen && trail && per[0]);
   c_phase_one: cover property (ready && lead && ctl[spi_link_pkg::BIT_PHASE]);
   c_slave_out: cover property (o_master_in_slave_out_pin_oe);
endmodule
bind spi_link_core spi_link_checker u_spi_link_checker (.*);

// File: tb/spi_link_partner.sv
// Purpose: slave device on the far side of the link
// Assumes: same polarity and phase as the core
// Notes: a released data line shows the inverse of its last level
`timescale 1ns/10ps
module spi_link_partner (
   // settings and reply byte
   input wire logic i_pol, i_pha,
   input wire logic [7:0] i_reply,
   // link pins
   input wire logic i_sclk, i_ste_n, i_mosi,
   output logic o_miso = 1'b0,
   // byte taken from the master
   output logic [7:0] o_got = 8'h00
);
   logic [7:0] sh; // bits still to send
   // put one bit out and move on
   task automatic launch();
      o_miso = sh[7];
      sh = sh << 1;
   endtask
   // frame start: phase 0 has the first bit out before any edge
   always @(negedge i_ste_n) begin
      sh = i_reply;
      o_got = 8'h00;
      if (!i_pha) launch();
   end
   // leading edge samples in phase 0, launches in phase 1
   always @(i_sclk) if (!i_ste_n) begin
      if ((i_sclk != i_pol) ^ i_pha) o_got = {o_got[6:0], i_mosi};
      else launch();
   end
   // released line must not keep a stale level
   always @(posedge i_ste_n) o_miso = ~o_miso;
endmodule

// File: tb/tb_spi_link_core.sv
// Purpose: self-checking bench for the serial link core
// Assumes: slave model as far side; bench is link master in slave role
// Notes: modes swept in order; divisors and bytes random around fixed corners
`timescale 1ns/10ps
module tb_spi_link_core;
   // clock, reset, register port
   logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000, o_rdata;
   // pins as the core drives them
   logic o_serial_clock_pin, o_serial_clock_pin_oe, o_master_out_slave_in_pin, o_master_out_slave_in_pin_oe;
   logic o_master_in_slave_out_pin, o_master_in_slave_out_pin_oe;
   logic o_transfer_enable_strobe_n, o_transfer_enable_strobe_n_oe;
   // far-side drive, settings, partner outputs
   logic m_sclk = 1'b0, m_ste_n = 1'b1, m_mosi = 1'b0, pol = 1'b0, pha = 1'b0, p_miso;
   logic [7:0] reply = 8'h00, got, tx;
   logic [6:0] dv;
   int n_errors = 0, n_tests = 0;
   // wire levels from each party's enable
   wire logic i_serial_clock_pin = o_serial_clock_pin_oe ? o_serial_clock_pin : m_sclk;
   wire logic i_transfer_enable_strobe_n = o_transfer_enable_strobe_n_oe ? o_transfer_enable_strobe_n : m_ste_n;
   wire logic i_master_out_slave_in_pin = o_master_out_slave_in_pin_oe ? o_master_out_slave_in_pin : m_mosi;
   wire logic i_master_in_slave_out_pin = o_master_in_slave_out_pin_oe ? o_master_in_slave_out_pin : p_miso;
   spi_link_core u_spi_link_core (.*);
   spi_link_partner u_spi_link_partner (.i_pol(pol), .i_pha(pha), .i_reply(reply), .i_sclk(i_serial_clock_pin),
      .i_ste_n(i_transfer_enable_strobe_n), .i_mosi(i_master_out_slave_in_pin), .o_miso(p_miso), .o_got(got));
   initial forever #50 i_sys_clk = ~i_sys_clk;
   // compare and count
   task automatic chk(input logic [15:0] seen, exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   // read strobe, data taken in the following cycle only
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk);
      v = o_rdata;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string what);
      logic [15:0] v;
      rd(a, v);
      chk(v, e, what);
   endtask
   // poll busy under a bound
   task automatic wait_idle();
      logic [15:0] s;
      for (int i = 0; i < 1000; i++) begin
         rd(spi_link_pkg::OFF_STATUS, s);
         if (s[spi_link_pkg::BIT_BUSY] === 1'b0) return;
      end
      chk(s, 16'h0000, "busy timeout");
   endtask
   // expected control word
   function automatic logic [15:0] ctl_word(input logic m, p);
      return 16'(m) << spi_link_pkg::BIT_MASTER | 16'(p) << spi_link_pkg::BIT_PHASE;
   endfunction
   task automatic setup(input logic m);
      wr(spi_link_pkg::OFF_LINK_CTL, ctl_word(m, pha));
      wr(spi_link_pkg::OFF_CHAR_CTL, 16'(pol) << spi_link_pkg::BIT_POLARITY);
      wr(spi_link_pkg::OFF_BAUD, 16'(dv));
      repeat (4) @(posedge i_sys_clk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge i_sys_clk);
      n_errors++;
      complete_run();
   end
   initial begin
      void'($urandom(17));
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      // reset values, unmapped place, clock pin released
      rchk(spi_link_pkg::OFF_LINK_CTL, spi_link_pkg::RST_LINK_CTL, "link ctl");
      rchk(spi_link_pkg::OFF_BAUD, 16'(spi_link_pkg::RST_BAUD), "baud");
      rchk(4'hF, 16'h0000, "unmapped");
      chk(16'(o_serial_clock_pin_oe), 16'h0000, "clock oe");
      // master in all modes: clamped, longest, odd, then random divisors
      for (int k = 0; k < 8; k++) begin
         {pol, pha} = k[1:0];
         dv = k == 0 ? 7'h01 : k == 1 ? 7'h7F : k == 2 ? 7'h04 : 7'($urandom_range(20, 3));
         tx = 8'($urandom);
         reply = 8'($urandom);
         setup(1'b1);
         wr(spi_link_pkg::OFF_TXDATA, 16'(tx));
         // a role change in mid-frame must be refused
         if (k == 2) begin
            repeat (4) @(posedge i_sys_clk);
            wr(spi_link_pkg::OFF_LINK_CTL, 16'h0000);
         end
         wait_idle();
         chk(16'(got), 16'(tx), "far side byte");
         rchk(spi_link_pkg::OFF_STATUS, 16'h0002, "done");
         rchk(spi_link_pkg::OFF_RXDATA, 16'(reply), "rx byte");
         rchk(spi_link_pkg::OFF_STATUS, 16'h0000, "done cleared");
         rchk(spi_link_pkg::OFF_LINK_CTL, ctl_word(1'b1, pha), "ctl kept");
      end
      // slave role: bench clocks at ten cycles a period
      for (int k = 0; k < 4; k++) begin
         {pol, pha} = k[1:0];
         tx = 8'($urandom);
         setup(1'b0);
         m_sclk <= pol;
         m_ste_n <= 1'b0;
         for (int b = 7; b >= 0; b--) begin
            m_mosi <= tx[b];
            if (pha) m_sclk <= ~pol;
            repeat (5) @(posedge i_sys_clk);
            m_sclk <= pha ? pol : ~pol;
            repeat (5) @(posedge i_sys_clk);
            if (!pha) m_sclk <= pol;
         end
         @(negedge i_sys_clk);
         chk(16'(o_master_in_slave_out_pin_oe), 16'h0001, "slave out oe");
         repeat (10) @(posedge i_sys_clk);
         m_ste_n <= 1'b1;
         m_mosi <= ~tx[0];
         repeat (10) @(posedge i_sys_clk);
         rchk(spi_link_pkg::OFF_RXDATA, 16'(tx), "slave rx");
      end
      complete_run();
   end
endmodule
